// File: led_ctrl_model.sv
// Purpose: Controller driving the serial link pins
// Assumes: Link clock period 125 ns, idle low between frames
// Notes:   Tied mode raises both clocks together
`timescale 1ns/100ps
module led_ctrl_model
(
   output logic shift_clock,
   output logic latch_clock,
   output logic serial_in
);
   initial {shift_clock, latch_clock, serial_in} = 3'h0;
   task automatic put(input logic b, input logic tie);
      serial_in = b;
      #62.5 shift_clock = 1'h1;
      latch_clock = tie;
      #62.5 {shift_clock, latch_clock} = 2'h0;
   endtask
   task automatic latch();
      #62.5 latch_clock = 1'h1;
      #62.5 latch_clock = 1'h0;
   endtask
endmodule

// File: led_driver_pkg.sv
// Purpose: Shared constants and carrier types for the sixteen-bit LED sink driver
// Assumes: Single system clock; all pin inputs are asynchronous to it
// Notes:   Stage index 0 is the first stage, index WIDTH-1 the last

package led_driver_pkg;

   localparam int           CHAIN_WIDTH   = 16;
   localparam int           SYNC_DEPTH    = 3;
   localparam logic [15:0]  STAGE_RESET   = 16'hffff;
   localparam logic         CASCADE_RESET = 1'h0;
   localparam logic         PIN_RESET     = 1'h0;

   // Three-stage sampler per pin
   typedef struct packed
   {
      logic [2:0] shift_clock;
      logic [2:0] latch_clock;
      logic [2:0] serial_in;
      logic [2:0] reset_n;
      logic [2:0] output_disable;
   } pin_sync_s;

   // Open-drain sink pin group
   typedef struct packed
   {
      logic [15:0] sink_out;
      logic [15:0] sink_oe;
   } sink_pins_s;

   typedef struct packed
   {
      pin_sync_s   sync;
      logic        shift_clock_prev;
      logic        latch_clock_prev;
      logic [15:0] shift_stages;
      logic [15:0] hold_stages;
      sink_pins_s  pins;
      logic        cascade;
   } driver_state_s;

endpackage

// File: led_driver_properties.sv
// Purpose: Port checks for the LED sink driver
// Assumes: Pin changes reach the outputs within six clk
// Notes:   Bound to the design module
`timescale 1ns/100ps
module led_driver_properties
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        shift_clock,
   input wire logic        latch_clock,
   input wire logic        serial_in,
   input wire logic        reset_n,
   input wire logic        output_disable,
   input wire logic [15:0] led_sink_outputs_out,
   input wire logic [15:0] led_sink_outputs_oe,
   input wire logic        cascade_serial_out
);
   wire [15:0] oe = led_sink_outputs_oe;
   wire        c  = cascade_serial_out;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_sink_zero: assert property (led_sink_outputs_out == 16'h0) else $error("drive");
   a_off_release: assert property (output_disable [*6] |-> oe == 16'h0) else $error("off");
   a_off_fast: assert property ($rose(output_disable) ##1 output_disable [*2] |->
      ##[0:4] oe == 16'h0) else $error("off late");
   a_rst_release: assert property (!reset_n [*6] |-> oe == 16'h0 && !c) else $error("rst");
   a_rst_fast: assert property (!reset_n [*3] |-> ##[0:3] !c) else $error("rst late");
   a_rst_sets: assert property ($rose(reset_n) ##1 (reset_n && !shift_clock) [*6] |-> c)
      else $error("set");
   a_latch_only: assert property ((!latch_clock && reset_n && !output_disable) [*8]
      |-> $stable(oe)) else $error("oe moved");
   a_shift_only: assert property ((!shift_clock && reset_n) [*8] |-> $stable(c))
      else $error("cascade moved");
   cover property ($rose(c));
   cover property ($fell(c));
   cover property (oe != 16'h0 && output_disable);
endmodule
bind led_shift_latch_driver16 led_driver_properties chk (.clk(clk), .rst(rst),
   .shift_clock(shift_clock), .latch_clock(latch_clock), .serial_in(serial_in),
   .reset_n(reset_n), .output_disable(output_disable), .led_sink_outputs_out(led_sink_outputs_out),
   .led_sink_outputs_oe(led_sink_outputs_oe), .cascade_serial_out(cascade_serial_out));

// File: led_shift_latch_driver16.sv
// Purpose: Sixteen-stage serial shift chain with holding latch, open-drain LED sinks
// Assumes: Pin clocks much slower than clk; pins sampled through three flip-flops
// Notes:   Pin edges take effect some clk cycles after the pin change
//
// Operation
// - Sixteen shift stages feed sixteen outputs through a separate holding latch
// - Each bit has a shift stage and a holding stage on separate clocks
// - Shift and latch act only on rising edges of their clocks
// - Shift edge loads first stage and moves others toward stage sixteen
// - First stage captures the inverse of the serial input
// - Latch edge copies all shift stages into the holding latch
// - Parallel outputs are open drain: low sinks, high releases
// - Cascade output shows the sixteenth shift stage
// - Cascade output is driven both high and low
// - Tied clocks show the shift chain delayed by one clock
// - Active-low reset reaches the outputs on the third clk after it falls, independent of shift and latch edges
// - Reset sets all stages, releases sinks, drives cascade low
// - Output disable releases sinks; cascade keeps showing last stage
// - Output disable leaves shifting and stored contents unaffected
// - Latch edge leaves shift stages and cascade output unchanged

`timescale 1ns/100ps

module led_shift_latch_driver16
   import led_driver_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   shift_clock,
   input  wire logic                   latch_clock,
   input  wire logic                   serial_in,
   input  wire logic                   reset_n,
   input  wire logic                   output_disable,
   output logic [CHAIN_WIDTH-1:0]      led_sink_outputs_out,
   output logic [CHAIN_WIDTH-1:0]      led_sink_outputs_oe,
   output logic                        cascade_serial_out
);

   driver_state_s state_reg;
   driver_state_s state_next;

   // -------------------------------------------------------------------------
   // Pin sampling and chain update
   // -------------------------------------------------------------------------
   always_comb
   begin
      logic shift_now;
      logic latch_now;
      logic shift_rise;
      logic latch_rise;
      logic in_reset;
      logic [CHAIN_WIDTH-1:0] new_shift;
      logic [CHAIN_WIDTH-1:0] new_hold;
      shift_now  = 1'h0;
      latch_now  = 1'h0;
      shift_rise = 1'h0;
      latch_rise = 1'h0;
      in_reset   = 1'h0;
      new_shift  = '0;
      new_hold   = '0;
      state_next = state_reg;
      state_next.sync.shift_clock    = {state_reg.sync.shift_clock[1:0], shift_clock};
      state_next.sync.latch_clock    = {state_reg.sync.latch_clock[1:0], latch_clock};
      state_next.sync.serial_in      = {state_reg.sync.serial_in[1:0], serial_in};
      state_next.sync.reset_n        = {state_reg.sync.reset_n[1:0], reset_n};
      state_next.sync.output_disable = {state_reg.sync.output_disable[1:0], output_disable};
      // Level changes only once stages two and three agree
      shift_now = (state_reg.sync.shift_clock[1] == state_reg.sync.shift_clock[2])
                  ? state_reg.sync.shift_clock[2] : state_reg.shift_clock_prev;
      latch_now = (state_reg.sync.latch_clock[1] == state_reg.sync.latch_clock[2])
                  ? state_reg.sync.latch_clock[2] : state_reg.latch_clock_prev;
      state_next.shift_clock_prev = shift_now;
      state_next.latch_clock_prev = latch_now;
      shift_rise = shift_now & ~state_reg.shift_clock_prev;
      latch_rise = latch_now & ~state_reg.latch_clock_prev;
      // Reset asserted as soon as either sampled stage sees it low
      in_reset = ~state_reg.sync.reset_n[1] | ~state_reg.sync.reset_n[2];
      new_shift = state_reg.shift_stages;
      new_hold  = state_reg.hold_stages;
      if (shift_rise)
      begin
         new_shift = {state_reg.shift_stages[CHAIN_WIDTH-2:0],
                      ~state_reg.sync.serial_in[2]};
      end
      if (latch_rise)
      begin
         new_hold = state_reg.shift_stages;
      end
      if (in_reset)
      begin
         new_shift = STAGE_RESET;
         new_hold  = STAGE_RESET;
      end
      state_next.shift_stages = new_shift;
      state_next.hold_stages  = new_hold;
      state_next.pins.sink_out = {CHAIN_WIDTH{PIN_RESET}};
      if (in_reset || state_reg.sync.output_disable[2])
      begin
         state_next.pins.sink_oe = '0;
      end
      else
      begin
         state_next.pins.sink_oe = ~new_hold;
      end
      state_next.cascade = in_reset ? CASCADE_RESET : new_shift[CHAIN_WIDTH-1];
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg                  <= '0;
         state_reg.sync.reset_n     <= 3'h7;
         state_reg.shift_stages     <= STAGE_RESET;
         state_reg.hold_stages      <= STAGE_RESET;
         state_reg.cascade          <= CASCADE_RESET;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign led_sink_outputs_out = state_reg.pins.sink_out;
   assign led_sink_outputs_oe  = state_reg.pins.sink_oe;
   assign cascade_serial_out   = state_reg.cascade;

endmodule

// File: led_shift_latch_driver16_tb_top.sv
// Purpose: Self-checking bench for the LED sink driver
// Assumes: Pin effects land within eight clk
// Notes:   Link pins come from the controller model
`timescale 1ns/100ps
module led_shift_latch_driver16_tb_top;
   logic clk = 1'h0, rst = 1'h1, reset_n = 1'h1, output_disable = 1'h0;
   logic [15:0] shown = 16'h0;
   wire        sck, lck, sdi, c;
   wire [15:0] out, oe;
   int         miscompares = 0, n_checks = 0;
   always #5 clk = ~clk;
   led_ctrl_model ctrl (.shift_clock(sck), .latch_clock(lck), .serial_in(sdi));
   led_shift_latch_driver16 uut (.clk(clk), .rst(rst), .shift_clock(sck), .latch_clock(lck),
      .serial_in(sdi), .reset_n(reset_n), .output_disable(output_disable),
      .led_sink_outputs_out(out), .led_sink_outputs_oe(oe), .cascade_serial_out(c));
   task automatic chk(input string n, input logic [15:0] e, g);
      n_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic settle();
      repeat (8) @(negedge clk);
   endtask
   task automatic word(input logic [15:0] lit);
      for (int i = 15; i >= 0; i--)
         ctrl.put(lit[i], 1'h0);
      settle();
      chk("cascade", {15'h0, ~lit[15]}, {15'h0, c});
      chk("before", shown, oe);
      ctrl.latch();
      settle();
      chk("latched", lit, oe);
      chk("sink drive", 16'h0, out);
      chk("kept", {15'h0, ~lit[15]}, {15'h0, c});
      shown = lit;
      $display("word %h done", lit);
   endtask
   task automatic tied();
      ctrl.put(1'h1, 1'h1);
      settle();
      chk("tied", shown, oe);
      ctrl.latch();
      settle();
      shown = {shown[14:0], 1'h1};
      chk("tied next", shown, oe);
      $display("tied done");
   endtask
   task automatic quiet();
      output_disable = 1'h1;
      settle();
      chk("off", 16'h0, oe);
      ctrl.put(1'h0, 1'h0);
      settle();
      chk("off cascade", {15'h0, ~shown[14]}, {15'h0, c});
      output_disable = 1'h0;
      settle();
      chk("on", shown, oe);
      $display("disable done");
   endtask
   task automatic pin_reset();
      reset_n = 1'h0;
      settle();
      chk("rst oe", 16'h0, oe);
      chk("rst cascade", 16'h0, {15'h0, c});
      reset_n = 1'h1;
      settle();
      chk("set cascade", 16'h1, {15'h0, c});
      chk("set hold", 16'h0, oe);
      ctrl.latch();
      settle();
      chk("set oe", 16'h0, oe);
      $display("pin reset done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(negedge clk);
      rst = 1'h0;
      word(16'h8001);
      word(16'h7ffe);
      tied();
      quiet();
      pin_reset();
      end_of_test();
   end
   initial
   begin
      #100us;
      miscompares++;
      end_of_test();
   end
endmodule
